/* File: hall_bridge_model.sv */
/*
  hall_bridge_model: three hall sensors and the three-phase power stage.
  assumes the bench changes the hall code and float mask on a rising pclk edge.
*/
`timescale 1ns/100ps
module hall_bridge_model
  import motor_ctl_pkg::*;
(
  // clock
  input wire logic pclk,
  // bench commands
  input wire logic [2:0] hall_code,
  input wire logic [2:0] hall_float,
  // sensor pins
  output logic hall_pos_a,
  output logic hall_pos_b,
  output logic hall_pos_c,
  output logic hall_a_driven,
  output logic hall_b_driven,
  output logic hall_c_driven,
  // power stage
  input wire bridge_drive_t bridge_drive,
  output logic shoot_seen
);
  // ---------------------------------------------------------------
  // sensors
  // ---------------------------------------------------------------
  logic [2:0] last_ff = 3'h0;
  logic shoot_ff = 1'b0;

  // codes come in 120-degree order, so no sensor is inverted here
  always @(posedge pclk) begin
    last_ff <= (hall_code & ~hall_float) | (last_ff & hall_float);
  end
  // a floating sensor line shows the inverse of its last level
  assign {hall_pos_a, hall_pos_b, hall_pos_c} = (hall_code & ~hall_float) | (~last_ff & hall_float);
  assign {hall_a_driven, hall_b_driven, hall_c_driven} = ~hall_float;

  // ---------------------------------------------------------------
  // power stage
  // ---------------------------------------------------------------
  // both switches of one phase on shorts the motor supply
  always @(posedge pclk) begin
    if (bridge_drive.a == 2'h3 || bridge_drive.b == 2'h3 || bridge_drive.c == 2'h3) begin
      shoot_ff <= 1'b1;
    end
  end
  assign shoot_seen = shoot_ff;
endmodule // hall_bridge_model

/* File: motor_ctl.sv */
/*
  motor_ctl: commutation, override and protection logic of a three-phase
  brushless driver, with an APB register file.
  assumes hall, brake, coast, speed and fault pins are asynchronous and are
  synchronised here; the power stage follows the bridge drive outputs.
*/
// Added by the designer: register access over APB and the placing of the registers.
// What this block does
// - each hall edge fires one fixed-length tach pulse, 113 us by default
// - hall latches stay frozen while the tach pulse is high
// - brake request turns highs off and lows on
// - coast request floats all three phases
// - undervoltage or overcurrent sets the soft-start latch
// - latch clears when ramp under restart level and no fault
// - pwm demand is limited to the soft-start ramp level
// - direction latch transparent at low speed, frozen at high speed
// - direction passes latch then two-bit shift register to decoder
// - latch or shift stage mismatch floats all phase outputs
// - shift register steps on pwm oscillator, dead time one to two periods
// - undriven hall inputs read as logic high
// - overcurrent keeps all phases disabled until it clears
// - chop select low chops lows only, high chops all; ignored in brake
// - phases follow hall code and latched direction
// - brake forced for about 200 us after power-up
`timescale 1ns/100ps
module motor_ctl
  import motor_ctl_pkg::*;
#(
  parameter int unsigned PWRUP_CYC = PWRUP_BRAKE_CYC,
  parameter int unsigned PWM_DIV = PWM_DIV_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // hall sensors, pull-up as enable-less input
  input wire logic hall_pos_a,
  input wire logic hall_pos_b,
  input wire logic hall_pos_c,
  input wire logic hall_a_driven,
  input wire logic hall_b_driven,
  input wire logic hall_c_driven,
  // protection pins
  input wire logic brake_timing_node_low,
  input wire logic coast_request,
  input wire logic vcc_under_turn_on,
  input wire logic overcurrent,
  input wire logic speed_above_thresh,
  // power stage
  output bridge_drive_t bridge_drive,
  output logic tach_out,
  output logic [7:0] pwm_limit
);

  typedef enum logic [2:0] {
    SS_CLAMP = 3'b001,
    SS_RAMP = 3'b010,
    SS_RUN = 3'b100
  } ss_state_t;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] async_in, meta_ff, sync_ff;
  logic [2:0] hall_raw;

  // undriven hall inputs read high
  assign hall_raw[2] = hall_a_driven ? hall_pos_a : 1'b1;
  assign hall_raw[1] = hall_b_driven ? hall_pos_b : 1'b1;
  assign hall_raw[0] = hall_c_driven ? hall_pos_c : 1'b1;
  assign async_in = {hall_raw, brake_timing_node_low, coast_request,
                     vcc_under_turn_on, overcurrent, speed_above_thresh};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= PIN_SYNC_RST;
      sync_ff <= PIN_SYNC_RST;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  logic [2:0] hall_s;
  logic brake_pin, coast_pin, uvlo, ocp, fast;
  assign hall_s = sync_ff[7:5];
  assign brake_pin = sync_ff[4];
  assign coast_pin = sync_ff[3];
  assign uvlo = sync_ff[2];
  assign ocp = sync_ff[1];
  assign fast = sync_ff[0];

  // ---------------------------------------------------------------
  // apb register file
  // ---------------------------------------------------------------
  logic [31:0] ctrl_ff, demand_ff;
  logic [15:0] tach_len_ff;
  logic [31:0] nxt_prdata;
  logic wr_en, rd_en, addr_ok;
  ctrl_fields_t ctl;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr == CTRL_OFS) || (paddr == DEMAND_OFS) ||
                   (paddr == STATUS_OFS) || (paddr == TACH_LEN_OFS);
  assign pslverr = psel && penable && !addr_ok;
  assign ctl.brake = ctrl_ff[CTRL_BRAKE_BIT];
  assign ctl.coast = ctrl_ff[CTRL_COAST_BIT];
  assign ctl.dir = ctrl_ff[CTRL_DIR_BIT];
  assign ctl.full_chop = ctrl_ff[CTRL_FULL_CHOP_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      demand_ff <= DEMAND_RST;
      tach_len_ff <= 16'(TACH_PULSE_CYC);
    end else if (wr_en) begin
      if (paddr == CTRL_OFS) ctrl_ff <= {28'h0, pwdata[3:0]};
      if (paddr == DEMAND_OFS) demand_ff <= {24'h0, pwdata[7:0]};
      if (paddr == TACH_LEN_OFS) tach_len_ff <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // tach one-shot and hall latch
  // ---------------------------------------------------------------
  logic tach_pulse;
  logic [2:0] hall_q;

  tach_oneshot #(.LEN_W(16)) u_tach (
    .pclk(pclk),
    .presetn(presetn),
    .hall_sync(hall_s),
    .pulse_len(tach_len_ff),
    .tach_pulse(tach_pulse),
    .hall_latched(hall_q)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tach_out <= 1'b0;
    else tach_out <= tach_pulse;
  end

  // ---------------------------------------------------------------
  // power-up brake timer
  // ---------------------------------------------------------------
  logic [15:0] pwrup_cnt_ff;
  logic pwrup_brake;
  assign pwrup_brake = (pwrup_cnt_ff != 16'(PWRUP_CYC));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pwrup_cnt_ff <= 16'h0000;
    else if (pwrup_brake) pwrup_cnt_ff <= pwrup_cnt_ff + 16'h0001;
  end

  // ---------------------------------------------------------------
  // pwm oscillator divider
  // ---------------------------------------------------------------
  logic [15:0] div_ff;
  logic osc_tick;
  assign osc_tick = (div_ff == 16'(PWM_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_ff <= 16'h0000;
    else if (osc_tick) div_ff <= 16'h0000;
    else div_ff <= div_ff + 16'h0001;
  end

  // ---------------------------------------------------------------
  // soft-start latch and ramp
  // ---------------------------------------------------------------
  ss_state_t ss_ff;
  logic [7:0] ramp_ff;
  logic fault;
  assign fault = uvlo || ocp;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_ff <= SS_CLAMP;
    end else begin
      unique case (ss_ff)
        SS_CLAMP: if (!fault && ramp_ff < SS_RESTART_LVL) ss_ff <= SS_RAMP;
        SS_RAMP: if (fault) ss_ff <= SS_CLAMP;
          else if (ramp_ff == SS_RAMP_MAX) ss_ff <= SS_RUN;
        SS_RUN: if (fault) ss_ff <= SS_CLAMP;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ramp_ff <= 8'h00;
    else if (ss_ff == SS_CLAMP) ramp_ff <= 8'h00;
    else if (osc_tick && ramp_ff != SS_RAMP_MAX) ramp_ff <= ramp_ff + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pwm_limit <= 8'h00;
    else if (demand_ff[7:0] > ramp_ff) pwm_limit <= ramp_ff;
    else pwm_limit <= demand_ff[7:0];
  end

  // ---------------------------------------------------------------
  // direction latch and two-bit shift register
  // ---------------------------------------------------------------
  logic dir_latch_ff;
  logic [1:0] dir_sr_ff;
  logic dir_blank;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dir_latch_ff <= 1'b0;
    else if (!fast) dir_latch_ff <= ctl.dir;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dir_sr_ff <= 2'b00;
    else if (osc_tick) dir_sr_ff <= {dir_sr_ff[0], dir_latch_ff};
  end

  assign dir_blank = (ctl.dir != dir_latch_ff) ||
                     (dir_latch_ff != dir_sr_ff[0]) ||
                     (dir_sr_ff[0] != dir_sr_ff[1]);

  // ---------------------------------------------------------------
  // commutation decode and overrides
  // ---------------------------------------------------------------
  // per phase: 2 = source, 1 = sink, 0 = hi-z
  function automatic logic [5:0] commutate(input logic dir, input logic [2:0] h);
    logic [5:0] r;
    r = 6'h00;
    unique case ({dir, h})
      4'b1001: r = {2'd0, 2'd1, 2'd2};
      4'b1011: r = {2'd1, 2'd0, 2'd2};
      4'b1010: r = {2'd1, 2'd2, 2'd0};
      4'b1110: r = {2'd0, 2'd2, 2'd1};
      4'b1100: r = {2'd2, 2'd0, 2'd1};
      4'b1101: r = {2'd2, 2'd1, 2'd0};
      4'b0101: r = {2'd1, 2'd2, 2'd0};
      4'b0100: r = {2'd1, 2'd0, 2'd2};
      4'b0110: r = {2'd0, 2'd1, 2'd2};
      4'b0010: r = {2'd2, 2'd1, 2'd0};
      4'b0011: r = {2'd2, 2'd0, 2'd1};
      4'b0001: r = {2'd0, 2'd2, 2'd1};
      default: r = 6'h00;
    endcase
    return r;
  endfunction

  logic brake_act, chop_on, full_chop_q;
  logic [5:0] code;
  bridge_drive_t nxt_drive;

  assign brake_act = brake_pin || ctl.brake || pwrup_brake;
  assign chop_on = (div_ff < 16'(PWM_DIV * pwm_limit / 256));
  assign code = commutate(dir_sr_ff[1], hall_q);

  // chop select frozen while braking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) full_chop_q <= 1'b0;
    else if (!brake_act) full_chop_q <= ctl.full_chop;
  end

  always_comb begin
    nxt_drive = '0;
    if (coast_pin || ctl.coast || dir_blank) begin
      nxt_drive = '0;
    end else if (ocp || ss_ff == SS_CLAMP) begin
      nxt_drive = '0;
    end else if (brake_act) begin
      nxt_drive.a = '{high_on: 1'b0, low_on: 1'b1};
      nxt_drive.b = '{high_on: 1'b0, low_on: 1'b1};
      nxt_drive.c = '{high_on: 1'b0, low_on: 1'b1};
    end else begin
      nxt_drive.a.high_on = (code[5:4] == 2'd2) && (chop_on || !full_chop_q);
      nxt_drive.a.low_on = (code[5:4] == 2'd1) && chop_on;
      nxt_drive.b.high_on = (code[3:2] == 2'd2) && (chop_on || !full_chop_q);
      nxt_drive.b.low_on = (code[3:2] == 2'd1) && chop_on;
      nxt_drive.c.high_on = (code[1:0] == 2'd2) && (chop_on || !full_chop_q);
      nxt_drive.c.low_on = (code[1:0] == 2'd1) && chop_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bridge_drive <= '0;
    else bridge_drive <= nxt_drive;
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (paddr == CTRL_OFS) nxt_prdata = ctrl_ff;
    if (paddr == DEMAND_OFS) nxt_prdata = demand_ff;
    if (paddr == TACH_LEN_OFS) nxt_prdata = {16'h0000, tach_len_ff};
    if (paddr == STATUS_OFS) begin
      nxt_prdata[STAT_SS_LATCH_BIT] = (ss_ff == SS_CLAMP);
      nxt_prdata[STAT_TACH_BIT] = tach_pulse;
      nxt_prdata[STAT_DIR_BIT] = dir_sr_ff[1];
      nxt_prdata[STAT_BLANK_BIT] = dir_blank;
      nxt_prdata[STAT_PWRUP_BIT] = pwrup_brake;
      nxt_prdata[STAT_HALL_LSB +: 3] = hall_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= nxt_prdata;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_coast_float: assert property (@(posedge pclk) disable iff (!presetn)
    (coast_pin || ctl.coast) |=> bridge_drive == '0)
    else $error("coast did not float phases");
  chk_brake_lows: assert property (@(posedge pclk) disable iff (!presetn)
    (brake_act && !coast_pin && !ctl.coast && !dir_blank && !ocp && ss_ff != SS_CLAMP)
      |=> bridge_drive == 6'b010101)
    else $error("brake drive wrong");
  chk_pwrup_brake: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(pwrup_brake) |-> $past(pwrup_cnt_ff) == 16'(PWRUP_CYC - 1))
    else $error("power-up brake length wrong");
  chk_ss_set: assert property (@(posedge pclk) disable iff (!presetn)
    fault |=> ss_ff == SS_CLAMP)
    else $error("soft-start latch not set on fault");
  chk_ss_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (ss_ff == SS_CLAMP && !fault && ramp_ff < SS_RESTART_LVL) |=> ss_ff == SS_RAMP)
    else $error("soft-start latch not cleared");
  chk_pwm_limit: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pwm_limit <= $past(ramp_ff))
    else $error("pwm above ramp");
  chk_dir_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    fast |=> $stable(dir_latch_ff))
    else $error("direction latch moved at speed");
  chk_dir_blank: assert property (@(posedge pclk) disable iff (!presetn)
    dir_blank |=> bridge_drive == '0)
    else $error("outputs driven during direction blank");
  chk_ocp_off: assert property (@(posedge pclk) disable iff (!presetn)
    ocp |=> bridge_drive == '0)
    else $error("outputs driven during overcurrent");
  chk_illegal_hall: assert property (@(posedge pclk) disable iff (!presetn)
    !brake_act && (hall_q == 3'h0 || hall_q == 3'h7) |=> bridge_drive == '0)
    else $error("illegal hall code drove outputs");
  chk_no_shoot: assert property (@(posedge pclk) disable iff (!presetn)
    !(bridge_drive.a.high_on && bridge_drive.a.low_on))
    else $error("phase a cross-conduction");

  cov_brake: cover property (@(posedge pclk) disable iff (!presetn) brake_act && !pwrup_brake);
  cov_run: cover property (@(posedge pclk) disable iff (!presetn) ss_ff == SS_RUN);
  cov_reverse: cover property (@(posedge pclk) disable iff (!presetn) $rose(dir_sr_ff[1]));
  cov_tach: cover property (@(posedge pclk) disable iff (!presetn) $rose(tach_out));

endmodule // motor_ctl

/* File: motor_ctl_pkg.sv */
/*
  motor_ctl_pkg: shared constants, timing counts and carrier types of the
  brushless motor commutation and protection logic.
  assumes a 25 MHz pclk and a 32-bit APB register bus.
*/
package motor_ctl_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned TACH_PULSE_NS = 113000;
  localparam int unsigned TACH_PULSE_CYC = (TACH_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PWRUP_BRAKE_NS = 200000;
  localparam int unsigned PWRUP_BRAKE_CYC = (PWRUP_BRAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PWM_HZ = 14800;
  localparam int unsigned PWM_DIV_CYC = CLK_HZ / PWM_HZ;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] DEMAND_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] TACH_LEN_OFS = 12'h00C;

  // control fields
  localparam int CTRL_BRAKE_BIT = 0;
  localparam int CTRL_COAST_BIT = 1;
  localparam int CTRL_DIR_BIT = 2;
  localparam int CTRL_FULL_CHOP_BIT = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DEMAND_RST = 32'h0000_0000;

  // status fields
  localparam int STAT_SS_LATCH_BIT = 0;
  localparam int STAT_TACH_BIT = 1;
  localparam int STAT_DIR_BIT = 2;
  localparam int STAT_BLANK_BIT = 3;
  localparam int STAT_PWRUP_BIT = 4;
  localparam int STAT_HALL_LSB = 8;

  // pin synchroniser reset: hall lines idle high on their pull-ups, other pins idle low
  localparam logic [7:0] PIN_SYNC_RST = 8'hE0;

  // soft-start ramp, 8-bit demand scale
  localparam logic [7:0] SS_RESTART_LVL = 8'h05;
  localparam logic [7:0] SS_RAMP_MAX = 8'hFF;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic high_on;
    logic low_on;
  } phase_drive_t;

  typedef struct packed {
    phase_drive_t a;
    phase_drive_t b;
    phase_drive_t c;
  } bridge_drive_t;

  typedef struct packed {
    logic brake;
    logic coast;
    logic dir;
    logic full_chop;
  } ctrl_fields_t;

endpackage

/* File: tach_oneshot.sv */
/*
  tach_oneshot: edge-triggered fixed-length pulse generator, not retriggered while a pulse runs.
  assumes hall inputs already synchronised to pclk.
*/
`timescale 1ns/100ps
module tach_oneshot
  import motor_ctl_pkg::*;
#(
  parameter int unsigned LEN_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // hall code and length
  input wire logic [2:0] hall_sync,
  input wire logic [LEN_W-1:0] pulse_len,
  // pulse out and frozen hall code
  output logic tach_pulse,
  output logic [2:0] hall_latched
);

  logic [LEN_W-1:0] cnt_ff;
  logic [2:0] hall_ff;
  logic change;

  assign change = (hall_sync != hall_ff) && (cnt_ff == '0);
  assign tach_pulse = (cnt_ff != '0);
  assign hall_latched = hall_ff;

  // ---------------------------------------------------------------
  // pulse counter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (change) begin
      cnt_ff <= pulse_len;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // hall latch, frozen while pulse active
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hall_ff <= 3'h7;
    end else if (cnt_ff == '0) begin
      hall_ff <= hall_sync;
    end
  end

  chk_hall_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    tach_pulse |=> $stable(hall_ff) || !$past(tach_pulse))
    else $error("hall latch moved during tach pulse");

endmodule // tach_oneshot

/* File: tb_top.sv */
/*
  tb_top: self-checking bench of the motor commutation and protection block.
  assumes the hall and bridge model stands in for sensors and power stage.
*/
`timescale 1ns/100ps
module tb_top
  import motor_ctl_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int PU = 50;
  localparam int PD = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, tach_out, shoot;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic hall_pos_a, hall_pos_b, hall_pos_c, hall_a_driven, hall_b_driven, hall_c_driven;
  logic brake_timing_node_low, coast_request, vcc_under_turn_on, overcurrent;
  logic speed_above_thresh;
  logic [2:0] hall_code, hall_float;
  logic [7:0] pwm_limit;
  bridge_drive_t bridge_drive, u, v;
  int fails = 0;
  int cmp_count = 0;
  int n;
  // {dir, hall code, expected bridge drive}
  logic [9:0] rows [14] = '{10'h246, 10'h2D2, 10'h298, 10'h389, 10'h321, 10'h364, 10'h158,
    10'h112, 10'h186, 10'h0A4, 10'h0E1, 10'h049, 10'h200, 10'h1C0};

  // ---------------------------------------------------------------
  // design and model
  // ---------------------------------------------------------------
  motor_ctl #(.PWRUP_CYC(PU), .PWM_DIV(PD)) u_motor_ctl (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hall_pos_a, .hall_pos_b,
    .hall_pos_c, .hall_a_driven, .hall_b_driven, .hall_c_driven, .brake_timing_node_low,
    .coast_request, .vcc_under_turn_on, .overcurrent, .speed_above_thresh, .bridge_drive,
    .tach_out, .pwm_limit);
  hall_bridge_model u_hall_bridge_model (.pclk, .hall_code, .hall_float, .hall_pos_a,
    .hall_pos_b, .hall_pos_c, .hall_a_driven, .hall_b_driven, .hall_c_driven, .bridge_drive,
    .shoot_seen(shoot));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tmo(input int lim);
    if (n >= lim) begin
      fails++;
      $display("CHECK FAILED wait expected below %0d seen %0d", lim, n);
      give_verdict();
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // one apb transfer; q and e take read data and error at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    tmo(20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // union u and intersection v of bridge drive over w cycles, so chopping cannot hide a switch
  task automatic look(input int c, input int w);
    cyc(c);
    u = '0;
    v = '1;
    repeat (w) begin
      @(negedge pclk);
      u = bridge_drive_t'(u | bridge_drive);
      v = bridge_drive_t'(v & bridge_drive);
    end
    @(posedge pclk);
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {brake_timing_node_low, coast_request, vcc_under_turn_on, overcurrent} = '0;
    speed_above_thresh = 1'b0;
    hall_code = 3'h1;
    hall_float = 3'h0;
    presetn = 1'b0;
    cyc(2);
    presetn <= 1'b1;
    apb(0, STATUS_OFS, 0);
    chk("pwrup_brake", 1, 32'(q[STAT_PWRUP_BIT]));
    apb(0, CTRL_OFS, 0);
    chk("ctrl_rst", CTRL_RST, q);
    apb(0, TACH_LEN_OFS, 0);
    chk("tach_len_rst", 32'h0000_0B09, q);
    cyc(PU);
    apb(0, STATUS_OFS, 0);
    chk("pwrup_end", 0, 32'(q[STAT_PWRUP_BIT]));
    apb(1, TACH_LEN_OFS, 32'h8);
    apb(1, DEMAND_OFS, 32'hFF);
    n = 0;
    while (pwm_limit !== 8'hFF && n < 8000) begin
      @(posedge pclk);
      n++;
    end
    tmo(8000);
    foreach (rows[i]) begin
      apb(1, CTRL_OFS, {29'h0, rows[i][9], 2'h0});
      hall_code <= rows[i][8:6];
      look(60, 40);
      chk("commutation", 32'(rows[i][5:0]), 32'(u));
    end
    hall_code <= 3'h1;
    brake_timing_node_low <= 1'b1;
    look(8, 40);
    chk("brake", 32'h15, 32'(u));
    apb(1, CTRL_OFS, 32'h8);
    look(8, 40);
    chk("brake_chop", 32'h15, 32'(u));
    coast_request <= 1'b1;
    look(8, 40);
    chk("coast_over_brake", 0, 32'(u));
    {brake_timing_node_low, coast_request} <= 2'h0;
    apb(1, CTRL_OFS, 32'h2);
    look(8, 40);
    chk("coast_reg", 0, 32'(u));
    apb(1, CTRL_OFS, 32'h0);
    overcurrent <= 1'b1;
    look(8, 40);
    chk("ovc_off", 0, 32'(u));
    apb(0, STATUS_OFS, 0);
    chk("ss_set_ovc", 1, 32'(q[STAT_SS_LATCH_BIT]));
    overcurrent <= 1'b0;
    cyc(20);
    chk("ramp_low", 1, 32'(pwm_limit < 8'h08));
    apb(0, STATUS_OFS, 0);
    chk("ss_clear", 0, 32'(q[STAT_SS_LATCH_BIT]));
    vcc_under_turn_on <= 1'b1;
    cyc(6);
    apb(0, STATUS_OFS, 0);
    chk("ss_set_uv", 1, 32'(q[STAT_SS_LATCH_BIT]));
    vcc_under_turn_on <= 1'b0;
    apb(1, DEMAND_OFS, 32'h40);
    n = 0;
    while (pwm_limit !== 8'h40 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    tmo(3000);
    cyc(40);
    chk("limit_demand", 32'h40, 32'(pwm_limit));
    speed_above_thresh <= 1'b1;
    cyc(4);
    apb(1, CTRL_OFS, 32'h4);
    look(60, 40);
    chk("dir_frozen", 0, 32'(u));
    apb(0, STATUS_OFS, 0);
    chk("dir_stat", 0, 32'(q[STAT_DIR_BIT]));
    speed_above_thresh <= 1'b0;
    look(5, 10);
    chk("dir_blank", 0, 32'(u));
    look(2 * PD, 40);
    chk("dir_new", 32'h06, 32'(u));
    chk("half_chop_hold", 32'h02, 32'(v));
    apb(1, CTRL_OFS, 32'hC);
    look(8, 40);
    chk("full_chop_on", 32'h06, 32'(u));
    chk("full_chop_off", 0, 32'(v));
    apb(1, TACH_LEN_OFS, 32'h14);
    hall_code <= 3'h3;
    n = 0;
    while (tach_out !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    tmo(20);
    n = 0;
    while (tach_out === 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chk("tach_width", 32'h14, 32'(n));
    cyc(60);
    hall_code <= 3'h2;
    n = 0;
    while (tach_out !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    tmo(20);
    hall_code <= 3'h6;
    apb(0, STATUS_OFS, 0);
    chk("hall_frozen", 32'h2, 32'(q[STAT_HALL_LSB +: 3]));
    cyc(60);
    hall_code <= 3'h3;
    cyc(60);
    hall_float <= 3'h3;
    look(60, 40);
    chk("pullup_bridge", 32'h12, 32'(u));
    apb(0, STATUS_OFS, 0);
    chk("hall_pullup", 32'h3, 32'(q[STAT_HALL_LSB +: 3]));
    hall_float <= 3'h0;
    apb(1, 12'h010, 32'hFFFF_FFFF);
    chk("slverr_wr", 1, 32'(e));
    apb(0, 12'h010, 0);
    chk("slverr_rd", 1, 32'(e));
    chk("unmapped_rd", 0, q);
    presetn <= 1'b0;
    cyc(2);
    chk("reset_bridge", 0, 32'(bridge_drive));
    presetn <= 1'b1;
    apb(0, CTRL_OFS, 0);
    chk("ctrl_after_reset", CTRL_RST, q);
    chk("shoot_through", 0, 32'(shoot));
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    fails++;
    give_verdict();
  end
endmodule // tb_top
